// >>> ace_pkg.sv
// shared constants for the audio crosspoint exchange: stream format, sizes, timing
// assumes a single 20 MHz clock domain inside the exchange
package ace_pkg;

  // =====================================================================
  // stream format
  localparam int SAMPLE_W = 24;                     // bits per sample and control word
  localparam int CHANS = 128;                       // channels per frame link
  localparam int CHAN_W = 7;                        // channel index width
  localparam int SLOT_W = 8;                        // slot 0 is the control word
  localparam int BIT_W = 5;                         // bit position within a word
  localparam logic [SAMPLE_W-1:0] SYNC_WORD = 24'hA5C3F0;
  localparam logic [SAMPLE_W-1:0] SILENCE = 24'h000000;

  // =====================================================================
  // exchange sizes
  localparam int IN_LINKS = 4;                      // input frame streams
  localparam int OUT_FRAMES = 4;                    // output frame streams
  localparam int PEER_LINKS = 3;                    // streams toward peer exchanges
  localparam int STREAMS = OUT_FRAMES + PEER_LINKS; // all outgoing streams
  localparam int STREAM_W = 3;                      // outgoing stream index width
  localparam int SRC_W = 9;                         // global input index width
  localparam int INPUTS = IN_LINKS * CHANS;         // 512 stored inputs

  // =====================================================================
  // routing commands and timing
  localparam int CMD_W = 1 + STREAM_W + CHAN_W + SRC_W;
  localparam int CMD_DEPTH = 8;                     // command buffer depth
  localparam int BIT_DIV = 4;                       // clocks per serial bit
  localparam int DIV_W = 2;

endpackage : ace_pkg

// >>> ace_cmd_fifo.sv
// small first-in first-out buffer for routing commands
// assumes one clock; the drain side may stall, ready on the fill side is registered
`timescale 1ns/100ps
module ace_cmd_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // =====================================================================
  // handshakes
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // pointers and fill level; ready is registered so the top sees a flop
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != (AW + 1)'(DEPTH));
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

endmodule : ace_cmd_fifo

// >>> ace_bus_collector.sv
// bus_collector: recovers words from one incoming packet stream
// assumes link_bit and link_strobe come from a pin, asynchronous to clock
`timescale 1ns/100ps
module ace_bus_collector
  import ace_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // serial link pins
  input wire logic link_bit,
  input wire logic link_strobe,
  // extracted samples
  output logic sample_valid,
  output logic [CHAN_W-1:0] sample_chan,
  output logic [SAMPLE_W-1:0] sample_data,
  output logic locked
);

  typedef enum logic {ACE_HUNT, ACE_LOCKED} ace_col_state_t;

  ace_col_state_t state;
  logic bit_s1, bit_s2;
  logic stb_s1, stb_s2, stb_s3;
  logic take;
  logic [SAMPLE_W-1:0] shreg;
  logic [SAMPLE_W-1:0] next_word;
  logic [BIT_W-1:0] bit_cnt;
  logic [SLOT_W-1:0] slot;

  // =====================================================================
  // pin synchronisers, two flops before any logic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bit_s1 <= 1'b0;
      bit_s2 <= 1'b0;
      stb_s1 <= 1'b0;
      stb_s2 <= 1'b0;
      stb_s3 <= 1'b0;
    end else begin
      bit_s1 <= link_bit;
      bit_s2 <= bit_s1;
      stb_s1 <= link_strobe;
      stb_s2 <= stb_s1;
      stb_s3 <= stb_s2;
    end
  end

  // bit taken on the strobe rising edge, same rate as the sender
  assign take = stb_s2 & ~stb_s3;
  assign next_word = {shreg[SAMPLE_W-2:0], bit_s2};

  // =====================================================================
  // word framing from the embedded control word
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ACE_HUNT;
      shreg <= '0;
      bit_cnt <= '0;
      slot <= '0;
      sample_valid <= 1'b0;
      sample_chan <= '0;
      sample_data <= '0;
    end else begin
      sample_valid <= 1'b0;
      if (take) begin
        shreg <= next_word;
        case (state)
          ACE_HUNT: begin
            // slide bit by bit until the control word lines up
            if (next_word == SYNC_WORD) begin
              state <= ACE_LOCKED;
              bit_cnt <= '0;
              slot <= SLOT_W'(1);
            end
          end
          ACE_LOCKED: begin
            if (bit_cnt == BIT_W'(SAMPLE_W - 1)) begin
              bit_cnt <= '0;
              if (slot == '0) begin
                // a missing control word means timing is lost
                if (next_word != SYNC_WORD) begin
                  state <= ACE_HUNT;
                end
                slot <= SLOT_W'(1);
              end else begin
                sample_valid <= 1'b1;
                sample_chan <= CHAN_W'(slot - 1'b1);
                sample_data <= next_word;
                slot <= (slot == SLOT_W'(CHANS)) ? '0 : slot + 1'b1;
              end
            end else begin
              bit_cnt <= bit_cnt + 1'b1;
            end
          end
          default: begin
            state <= ACE_HUNT;
          end
        endcase
      end
    end
  end

  assign locked = (state == ACE_LOCKED);

endmodule : ace_bus_collector

// >>> ace_exchange.sv
// central exchange: collects input frame streams, stores every input sample,
// and builds one outgoing stream per output frame and per peer exchange
// assumes link pins are asynchronous; routing commands come from same-clock logic
//
// Functional notes
// - senders emit stored words plus control words
// - collectors frame words from embedded control words
// - bits clocked by synchronized strobe, same rate
// - each sample stored at its input's location
// - output path reads chosen input in order
// - several outputs may read one input
// - every link carries up to 128 channels
// - input link n supplies consecutive block of 128
// - all 512 inputs stored and reachable
// - one dedicated stream per output frame
// - stream holds inputs assigned to that frame
// - stream content follows controller routing commands
// - own 512 inputs offered to peer exchanges
// - peer streams carry only inputs peers need
`timescale 1ns/100ps
module ace_exchange
  import ace_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // input frame links
  input wire logic [IN_LINKS-1:0] in_bit,
  input wire logic [IN_LINKS-1:0] in_strobe,
  output logic [IN_LINKS-1:0] in_locked,
  // routing commands from the frame supervisor
  input wire logic cmd_valid,
  input wire logic [STREAM_W-1:0] cmd_stream,
  input wire logic [CHAN_W-1:0] cmd_chan,
  input wire logic [SRC_W-1:0] cmd_source,
  input wire logic cmd_enable,
  output logic cmd_ready,
  // outgoing streams: output frames first, then peer exchanges
  output logic [STREAMS-1:0] out_bit,
  output logic [STREAMS-1:0] out_strobe
);

  // =====================================================================
  // declarations
  logic [SAMPLE_W-1:0] sample_mem [INPUTS];
  logic [IN_LINKS-1:0] col_valid;
  logic [CHAN_W-1:0] col_chan [IN_LINKS];
  logic [SAMPLE_W-1:0] col_data [IN_LINKS];

  logic shadow_v [STREAMS][CHANS];
  logic [SRC_W-1:0] shadow_src [STREAMS][CHANS];

  logic [DIV_W-1:0] div_cnt;
  logic bit_tick;
  logic strobe_q;

  logic [CMD_W-1:0] fifo_in;
  logic fifo_out_valid;
  logic [CMD_W-1:0] fifo_out;
  logic drain;
  logic d_enable;
  logic [STREAM_W-1:0] d_stream;
  logic [CHAN_W-1:0] d_chan;
  logic [SRC_W-1:0] d_source;

  // global input index of a channel on a given link
  function automatic logic [SRC_W-1:0] ace_global_index(input int link,
                                                        input logic [CHAN_W-1:0] chan);
    ace_global_index = SRC_W'(link * CHANS) + SRC_W'(chan);
  endfunction : ace_global_index

  // =====================================================================
  // input side: one collector per input frame link
  generate
    for (genvar l = 0; l < IN_LINKS; l++) begin : g_in
      ace_bus_collector u_collector (
        .clock(clock),
        .arst_n(arst_n),
        .link_bit(in_bit[l]),
        .link_strobe(in_strobe[l]),
        .sample_valid(col_valid[l]),
        .sample_chan(col_chan[l]),
        .sample_data(col_data[l]),
        .locked(in_locked[l])
      );
    end
  endgenerate

  // the input frames sample their inputs in turn; nothing here depends on that order
  // beyond channel numbering in the stream

  // =====================================================================
  // sample store: one location per global input
  // links own disjoint blocks, so simultaneous writes never collide
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < INPUTS; i++) begin
        sample_mem[i] <= SILENCE;
      end
    end else begin
      for (int l = 0; l < IN_LINKS; l++) begin
        if (col_valid[l]) begin
          sample_mem[ace_global_index(l, col_chan[l])] <= col_data[l];
        end
      end
    end
  end

  // =====================================================================
  // bit rate divider: one bit per BIT_DIV clocks, strobe high in second half
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
      strobe_q <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == DIV_W'(BIT_DIV - 1)) ? '0 : div_cnt + 1'b1;
      strobe_q <= (div_cnt >= DIV_W'(BIT_DIV / 2 - 1)) && (div_cnt != DIV_W'(BIT_DIV - 1));
    end
  end

  assign bit_tick = (div_cnt == DIV_W'(BIT_DIV - 1));
  // one strobe flop serves every stream, so all streams share the bit rate
  assign out_strobe = {STREAMS{strobe_q}};

  // =====================================================================
  // routing command buffer
  assign fifo_in = {cmd_enable, cmd_stream, cmd_chan, cmd_source};

  ace_cmd_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(CMD_DEPTH)
  ) u_cmd_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .in_valid(cmd_valid),
    .in_data(fifo_in),
    .in_ready(cmd_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out),
    .out_ready(bit_tick)
  );

  // commands are applied at most one per bit time; this paces map churn and
  // lets a burst from the supervisor back up into the buffer
  assign drain = fifo_out_valid & bit_tick;
  assign {d_enable, d_stream, d_chan, d_source} = fifo_out;

  // =====================================================================
  // shadow routing map, written by commands at any time
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < STREAMS; s++) begin
        for (int c = 0; c < CHANS; c++) begin
          shadow_v[s][c] <= 1'b0;
          shadow_src[s][c] <= '0;
        end
      end
    end else if (drain && (d_stream < STREAM_W'(STREAMS))) begin
      // out-of-range stream numbers are dropped silently
      shadow_v[d_stream][d_chan] <= d_enable;
      shadow_src[d_stream][d_chan] <= d_source;
    end
  end

  // =====================================================================
  // outgoing streams: output frames and peer exchanges share one builder
  generate
    for (genvar s = 0; s < STREAMS; s++) begin : g_out
      logic act_v [CHANS];
      logic [SRC_W-1:0] act_src [CHANS];
      logic [SAMPLE_W-1:0] shreg;
      logic [BIT_W-1:0] bit_idx;
      logic [SLOT_W-1:0] slot;
      logic [SLOT_W-1:0] next_slot;
      logic [CHAN_W-1:0] next_chan;
      logic [SAMPLE_W-1:0] next_word;

      // slot 0 is the control word, slots 1..128 are channels 0..127
      assign next_slot = (slot == SLOT_W'(CHANS)) ? '0 : slot + 1'b1;
      assign next_chan = CHAN_W'(next_slot - 1'b1);

      // each path reads the store on its own, so one input may feed many streams
      always_comb begin
        if (next_slot == '0) begin
          next_word = SYNC_WORD;
        end else if (act_v[next_chan]) begin
          next_word = sample_mem[act_src[next_chan]];
        end else begin
          next_word = SILENCE;
        end
      end

      // shift the word out and step through the slots
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          shreg <= SYNC_WORD;
          bit_idx <= '0;
          slot <= '0;
          out_bit[s] <= 1'b0;
        end else if (bit_tick) begin
          out_bit[s] <= shreg[SAMPLE_W-1];
          if (bit_idx == BIT_W'(SAMPLE_W - 1)) begin
            bit_idx <= '0;
            slot <= next_slot;
            shreg <= next_word;
          end else begin
            bit_idx <= bit_idx + 1'b1;
            shreg <= {shreg[SAMPLE_W-2:0], 1'b0};
          end
        end
      end

      // the live map is copied only when the control word is loaded, so a
      // frame never mixes two routings; a change waits up to one frame
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          for (int c = 0; c < CHANS; c++) begin
            act_v[c] <= 1'b0;
            act_src[c] <= '0;
          end
        end else if (bit_tick && (bit_idx == BIT_W'(SAMPLE_W - 1)) && (next_slot == '0)) begin
          for (int c = 0; c < CHANS; c++) begin
            act_v[c] <= shadow_v[s][c];
            act_src[c] <= shadow_src[s][c];
          end
        end
      end
    end
  endgenerate

  // streams OUT_FRAMES..STREAMS-1 face peer exchanges; any of the 512 stored
  // inputs can be mapped there, so each peer gets what its outputs need
  // the far output frame rebuilds channels from the slot order used here

endmodule : ace_exchange

// >>> ace_in_frame_model.sv
// input frame model: sends endless frames of one control word and 128 samples
// assumes the bench raises run after reset; strobe stands still between frames
`timescale 1ns/100ps
module ace_in_frame_model
  import ace_pkg::*;
#(
  parameter int LINK = 0
) (
  // clock and start
  input wire logic clock,
  input wire logic run,
  // serial link pins
  output logic link_bit,
  output logic link_strobe
);
  // =====================================================================
  // sample content names its link and channel so misrouting shows
  function automatic logic [SAMPLE_W-1:0] model_sample(input int k);
    return 24'h600000 | SAMPLE_W'(LINK << 12) | SAMPLE_W'(k);
  endfunction : model_sample

  logic [SAMPLE_W-1:0] word;

  // bit period of four clocks, same rate the exchange sends at
  initial begin
    link_bit = 1'b0;
    link_strobe = 1'b0;
    wait (run);
    forever begin
      for (int k = 0; k <= CHANS; k++) begin
        word = (k == 0) ? SYNC_WORD : model_sample(k - 1);
        for (int b = SAMPLE_W - 1; b >= 0; b--) begin
          @(posedge clock);
          #1;
          link_bit = word[b];
          link_strobe = 1'b0;
          @(posedge clock);
          @(posedge clock);
          #1;
          link_strobe = 1'b1;
          @(posedge clock);
        end
      end
      // idle gap: data toggles so a stale level is never mistaken for a bit
      repeat (6) begin
        @(posedge clock);
        #1;
        link_strobe = 1'b0;
        link_bit = ~link_bit;
      end
    end
  end
endmodule : ace_in_frame_model

// >>> ace_exchange_chk.sv
// checker for the exchange: link lock, command buffer and outgoing strobe timing
// assumes it is bound to ace_exchange and sees only its ports
`timescale 1ns/100ps
module ace_exchange_chk
  import ace_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // input frame links
  input wire logic [IN_LINKS-1:0] in_bit,
  input wire logic [IN_LINKS-1:0] in_strobe,
  input wire logic [IN_LINKS-1:0] in_locked,
  // routing commands
  input wire logic cmd_valid,
  input wire logic [STREAM_W-1:0] cmd_stream,
  input wire logic [CHAN_W-1:0] cmd_chan,
  input wire logic [SRC_W-1:0] cmd_source,
  input wire logic cmd_enable,
  input wire logic cmd_ready,
  // outgoing streams
  input wire logic [STREAMS-1:0] out_bit,
  input wire logic [STREAMS-1:0] out_strobe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  int idle_cnt;

  // clocks since link 0 strobe moved; lock must not change on an idle link
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt <= 1000;
    end else if ($changed(in_strobe[0])) begin
      idle_cnt <= 0;
    end else if (idle_cnt < 1000) begin
      idle_cnt <= idle_cnt + 1;
    end
  end

  // =====================================================================
  // assertions
  a_reset_quiet: assert property ($rose(arst_n) |-> in_locked == '0 && cmd_ready
    && out_bit == '0 && out_strobe == '0) else $error("outputs not idle after reset");
  a_strobe_high: assert property ($rose(out_strobe[0]) |-> out_strobe[0] ##1 out_strobe[0]
    ##1 !out_strobe[0]) else $error("strobe high time wrong");
  a_strobe_low: assert property ($fell(out_strobe[0]) |-> !out_strobe[0][*2]
    ##1 out_strobe[0]) else $error("strobe low time wrong");
  a_strobes_same: assert property (out_strobe == {STREAMS{out_strobe[0]}})
    else $error("stream strobes differ");
  a_bit_hold: assert property (out_strobe[0] |-> $stable(out_bit))
    else $error("data moved under strobe");
  a_lock_needs_bits: assert property ($changed(in_locked[0]) |-> idle_cnt < 8)
    else $error("lock changed on idle link");
  a_ready_cause: assert property ($fell(cmd_ready) |-> $past(cmd_valid))
    else $error("ready fell without a command");
  a_ready_return: assert property ($fell(cmd_ready) |-> ##[1:12] cmd_ready)
    else $error("buffer did not drain");

  // main scenarios
  c_lock: cover property ($rose(in_locked[0]));
  c_full: cover property ($fell(cmd_ready));
  c_clear: cover property (cmd_valid && cmd_ready && !cmd_enable);
endmodule : ace_exchange_chk

bind ace_exchange ace_exchange_chk u_chk (
  .clock(clock), .arst_n(arst_n), .in_bit(in_bit), .in_strobe(in_strobe),
  .in_locked(in_locked), .cmd_valid(cmd_valid), .cmd_stream(cmd_stream),
  .cmd_chan(cmd_chan), .cmd_source(cmd_source), .cmd_enable(cmd_enable),
  .cmd_ready(cmd_ready), .out_bit(out_bit), .out_strobe(out_strobe)
);

// >>> testbench.sv
// testbench: four input frame models feed the exchange; all outgoing streams decoded
// assumes frames run without end once started; inputs change 1 ns after the clock
`timescale 1ns/100ps
module testbench
  import ace_pkg::*;
;
  logic clock;
  logic arst_n;
  logic run;
  wire logic [IN_LINKS-1:0] in_bit;
  wire logic [IN_LINKS-1:0] in_strobe;
  wire logic [IN_LINKS-1:0] in_locked;
  logic cmd_valid;
  logic [STREAM_W-1:0] cmd_stream;
  logic [CHAN_W-1:0] cmd_chan;
  logic [SRC_W-1:0] cmd_source;
  logic cmd_enable;
  wire logic cmd_ready;
  wire logic [STREAMS-1:0] out_bit;
  wire logic [STREAMS-1:0] out_strobe;
  int error_cnt = 0;
  int samples_checked = 0;
  logic saw_full;
  logic [SAMPLE_W-1:0] cap [STREAMS][CHANS];
  logic [SAMPLE_W-1:0] exp_map [STREAMS][CHANS];
  int frames [STREAMS] = '{default: 0};

  ace_exchange dut (
    .clock(clock), .arst_n(arst_n), .in_bit(in_bit), .in_strobe(in_strobe),
    .in_locked(in_locked), .cmd_valid(cmd_valid), .cmd_stream(cmd_stream),
    .cmd_chan(cmd_chan), .cmd_source(cmd_source), .cmd_enable(cmd_enable),
    .cmd_ready(cmd_ready), .out_bit(out_bit), .out_strobe(out_strobe)
  );

  for (genvar l = 0; l < IN_LINKS; l++) begin : g_link
    ace_in_frame_model #(.LINK(l)) u_frame (
      .clock(clock), .run(run), .link_bit(in_bit[l]), .link_strobe(in_strobe[l])
    );
  end

  // =====================================================================
  // compare and control tasks
  function automatic logic [SAMPLE_W-1:0] exp_sample(input int src);
    return 24'h600000 | SAMPLE_W'((src / CHANS) << 12) | SAMPLE_W'(src % CHANS);
  endfunction : exp_sample

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic fail_wait(input string what);
    error_cnt++;
    $display("CHECK FAILED %s expected progress seen timeout", what);
    end_of_test();
  endtask : fail_wait

  task automatic chk_word(input string what, input logic [SAMPLE_W-1:0] exp,
                          input logic [SAMPLE_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_flag

  // caller holds cmd_valid; fields move only after the edge that took the last one
  task automatic send_cmd(input int s, input int c, input int src, input logic en);
    int t;
    cmd_stream = STREAM_W'(s);
    cmd_chan = CHAN_W'(c);
    cmd_source = SRC_W'(src);
    cmd_enable = en;
    t = 0;
    while (cmd_ready !== 1'b1 && t < 40) begin
      saw_full = 1'b1;
      @(posedge clock);
      #1;
      t++;
    end
    if (t >= 40) fail_wait("cmd_ready");
    @(posedge clock);
    #1;
    exp_map[s][c] = en ? exp_sample(src) : SILENCE;
  endtask : send_cmd

  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (frames[STREAMS-1] < n && t < 30000) begin
      @(posedge clock);
      #1;
      t++;
    end
    if (t >= 30000) fail_wait("frame count");
  endtask : wait_frames

  // =====================================================================
  // scenarios
  task automatic test_reset;
    #1;
    chk_flag("in_locked", 8'h00, {4'h0, in_locked});
    chk_flag("cmd_ready", 8'h01, {7'h00, cmd_ready});
    chk_flag("out_bit", 8'h00, {1'b0, out_bit});
    chk_flag("out_strobe", 8'h00, {1'b0, out_strobe});
    arst_n = 1'b1;
  endtask : test_reset

  task automatic test_lock;
    int t;
    repeat (3) @(posedge clock);
    #1;
    run = 1'b1;
    t = 0;
    while (in_locked !== 4'hF && t < 400) begin
      @(posedge clock);
      #1;
      t++;
    end
    if (t >= 400) fail_wait("link lock");
    chk_flag("in_locked", 8'h0F, {4'h0, in_locked});
  endtask : test_lock

  // sixteen routes back to back overrun the buffer; one source feeds two streams
  task automatic test_route;
    saw_full = 1'b0;
    cmd_valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      send_cmd(i % 5, i * 8 + 3, (i == 14) ? 0 : (i * 97) % INPUTS, 1'b1);
    end
    cmd_valid = 1'b0;
    chk_flag("buffer full seen", 8'h01, {7'h00, saw_full});
    wait_frames(2);
    for (int s = 0; s < STREAMS; s++) begin
      for (int k = 0; k < CHANS; k++) begin
        chk_word($sformatf("stream %0d slot %0d", s, k), exp_map[s][k], cap[s][k]);
      end
    end
  endtask : test_route

  // change issued early in a frame must wait for the next frame
  task automatic test_change;
    repeat (200) @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    send_cmd(0, 3, INPUTS - 1, 1'b1);
    send_cmd(4, 115, 0, 1'b0);
    cmd_valid = 1'b0;
    wait_frames(3);
    chk_word("old route", exp_sample(0), cap[0][3]);
    chk_word("old route", exp_sample(0), cap[4][115]);
    wait_frames(4);
    chk_word("new route", exp_map[0][3], cap[0][3]);
    chk_word("silenced", exp_map[4][115], cap[4][115]);
    chk_flag("in_locked", 8'h0F, {4'h0, in_locked});
  endtask : test_change

  // decode each stream at its strobe; hunt the control word only once after reset
  for (genvar s = 0; s < STREAMS; s++) begin : g_mon
    logic [SAMPLE_W-1:0] sh = '0;
    int nb = 0;
    int slot = -1;
    always @(posedge out_strobe[s]) begin
      sh = {sh[SAMPLE_W-2:0], out_bit[s]};
      nb = nb + 1;
      if (slot < 0 && sh === SYNC_WORD) begin
        slot = 0;
        nb = 0;
      end else if (slot >= 0 && nb == SAMPLE_W) begin
        nb = 0;
        if (slot == CHANS) begin
          chk_word("control word", SYNC_WORD, sh);
          slot = 0;
        end else begin
          cap[s][slot] = sh;
          slot = slot + 1;
          if (slot == CHANS) frames[s] = frames[s] + 1;
        end
      end
    end
  end

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // cut a hang short well inside the cycle budget
  initial begin
    repeat (90000) @(posedge clock);
    fail_wait("run length");
  end

  // main sequence
  initial begin
    arst_n = 1'b0;
    run = 1'b0;
    cmd_valid = 1'b0;
    cmd_stream = '0;
    cmd_chan = '0;
    cmd_source = '0;
    cmd_enable = 1'b0;
    for (int s = 0; s < STREAMS; s++) begin
      for (int k = 0; k < CHANS; k++) begin
        exp_map[s][k] = SILENCE;
      end
    end
    repeat (20) @(posedge clock);
    test_reset();
    test_lock();
    test_route();
    test_change();
    end_of_test();
  end
endmodule : testbench
